// *** rtl/event_timer_unit.sv ***
// Sixteen-bit event capture timer with an AXI4-Lite register slave.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_map.svh"
// Overview of operation
// - Count from peripheral or companion timer clock.
// - Clock select picks one prescaler output.
// - Six modes, two more codes stop; periodic mode, timer disabled, after reset.
// - BOTTOM is 0x0000, MAX is 0xFFFF.
// - Periodic: match at TOP, event, restart.
// - TOP below count: run to MAX, wrap.
// - Time-out: start edge starts, next stops.
// - Time-out: TOP before stop raises flag.
// - Time-out: frozen until next start edge.
// - Frozen: reads and run writes harmless.
// - Capture event: free run, copy on edge.
// - Capture edge selectable rising or falling.
// - Capture read clears match flag.
// - Frequency: capture and restart on edge.
// - Pulse width: restart rise, capture fall.
// - Combined: start, capture fall, stop rise.
// - Readable running status bit.
module event_timer_unit
    import event_timer_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic event_in,
    input wire logic companion_tick,
    output logic match_event,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import event_timer_pkg::*;

    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    logic en_r;
    logic [1:0] clock_source_select_r;
    mode_t mode_r;
    logic edge_r;
    logic flag_r;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] capture_compare_value_r, capture_compare_value_nxt;
    logic run_r, run_nxt;
    fp_phase_t phase_r, phase_nxt;
    logic div_r;
    logic ev_d_r;
    logic hit;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = a == `OFS_CTRL_A || a == `OFS_CTRL_B || a == `OFS_EV_CTRL
            || a == `OFS_STATUS || a == `OFS_FLAGS || a == `OFS_COUNT
            || a == `OFS_CAPTURE_COMPARE_VALUE;
    endfunction : is_mapped

    function automatic logic is_capture(input mode_t m);
        is_capture = m == M_MATCH_EVENT_FLAG_EVENT || m == M_MATCH_EVENT_FLAG_FREQ
            || m == M_MATCH_EVENT_FLAG_PW || m == M_MATCH_EVENT_FLAG_FRQPW;
    endfunction : is_capture

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic wr_go;
    assign wr_go = !awready && !wready && !bvalid;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                waddr_r <= awaddr[7:0];
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= is_mapped(waddr_r) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    logic wr_lo;
    logic wr_count;
    logic wr_capture_compare_value;
    assign wr_lo = wr_go && wstrb_r[0];
    assign wr_count = wr_go && waddr_r == `OFS_COUNT && wstrb_r[1:0] != 2'h0;
    assign wr_capture_compare_value = wr_go && waddr_r == `OFS_CAPTURE_COMPARE_VALUE && wstrb_r[1:0] != 2'h0;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            en_r <= 1'b0;
            clock_source_select_r <= `CLOCK_SOURCE_SELECT_PER;
            mode_r <= M_PERIODIC;
            edge_r <= 1'b0;
        end else if (wr_lo) begin
            if (waddr_r == `OFS_CTRL_A) begin
                en_r <= wdata_r[`ENABLE_BIT];
                clock_source_select_r <= wdata_r[`CLOCK_SOURCE_SELECT_MSB:`CLOCK_SOURCE_SELECT_LSB];
            end
            if (waddr_r == `OFS_CTRL_B) begin
                mode_r <= mode_t'(wdata_r[`MODE_MSB:0]);
            end
            if (waddr_r == `OFS_EV_CTRL) begin
                edge_r <= wdata_r[`EDGE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Prescaler and event edges
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_r <= 1'b0;
            ev_d_r <= 1'b0;
        end else begin
            div_r <= !div_r;
            ev_d_r <= event_in;
        end
    end

    logic tick;
    always_comb begin
        unique case (clock_source_select_r)
            `CLOCK_SOURCE_SELECT_PER: tick = 1'b1;
            `CLOCK_SOURCE_SELECT_DIV2: tick = div_r;
            `CLOCK_SOURCE_SELECT_COMP: tick = companion_tick;
            default: tick = 1'b0;
        endcase
    end

    logic rise_e, fall_e, sel_e, stop_e;
    assign rise_e = event_in && !ev_d_r;
    assign fall_e = !event_in && ev_d_r;
    assign sel_e = edge_r ? fall_e : rise_e;
    assign stop_e = edge_r ? rise_e : fall_e;

    // ------------------------------------------------------------
    // Counter and capture logic
    // ------------------------------------------------------------
    logic [15:0] inc;
    assign inc = 16'(cnt_r + `CNT_ONE);

    always_comb begin
        cnt_nxt = cnt_r;
        capture_compare_value_nxt = capture_compare_value_r;
        run_nxt = run_r;
        phase_nxt = phase_r;
        hit = 1'b0;
        if (!en_r) begin
            run_nxt = 1'b0;
            phase_nxt = FP_IDLE;
        end else begin
            unique case (mode_r)
                M_PERIODIC: begin
                    run_nxt = 1'b1;
                    if (tick) begin
                        hit = cnt_r == capture_compare_value_r;
                        cnt_nxt = hit ? `CNT_BOTTOM : inc;
                    end
                end
                M_TIMEOUT: begin
                    if (!run_r) begin
                        if (sel_e) begin
                            run_nxt = 1'b1;
                            cnt_nxt = `CNT_BOTTOM;
                        end
                    end else if (stop_e) begin
                        run_nxt = 1'b0;
                    end else if (tick) begin
                        hit = cnt_r == capture_compare_value_r;
                        cnt_nxt = inc;
                    end
                end
                M_MATCH_EVENT_FLAG_EVENT: begin
                    run_nxt = 1'b1;
                    if (tick) begin
                        cnt_nxt = inc;
                    end
                    if (sel_e) begin
                        capture_compare_value_nxt = cnt_r;
                        hit = 1'b1;
                    end
                end
                M_MATCH_EVENT_FLAG_FREQ: begin
                    run_nxt = 1'b1;
                    if (sel_e) begin
                        capture_compare_value_nxt = cnt_r;
                        cnt_nxt = `CNT_BOTTOM;
                        hit = 1'b1;
                    end else if (tick) begin
                        cnt_nxt = inc;
                    end
                end
                M_MATCH_EVENT_FLAG_PW: begin
                    run_nxt = 1'b1;
                    if (rise_e) begin
                        cnt_nxt = `CNT_BOTTOM;
                    end else begin
                        if (fall_e) begin
                            capture_compare_value_nxt = cnt_r;
                            hit = 1'b1;
                        end
                        if (tick) begin
                            cnt_nxt = inc;
                        end
                    end
                end
                M_MATCH_EVENT_FLAG_FRQPW: begin
                    unique case (phase_r)
                        FP_IDLE: begin
                            if (rise_e) begin
                                cnt_nxt = `CNT_BOTTOM;
                                run_nxt = 1'b1;
                                phase_nxt = FP_HIGH;
                            end
                        end
                        FP_HIGH: begin
                            if (fall_e) begin
                                capture_compare_value_nxt = cnt_r;
                                phase_nxt = FP_LOW;
                            end else if (tick) begin
                                cnt_nxt = inc;
                            end
                        end
                        FP_LOW: begin
                            if (rise_e) begin
                                run_nxt = 1'b0;
                                hit = 1'b1;
                                phase_nxt = FP_DONE;
                            end else if (tick) begin
                                cnt_nxt = inc;
                            end
                        end
                        FP_DONE: begin
                            if (!flag_r) begin
                                phase_nxt = FP_IDLE;
                            end
                        end
                    endcase
                end
                default: begin
                    run_nxt = 1'b0;
                end
            endcase
        end
        if (wr_count) begin
            cnt_nxt = merge16(cnt_r, wdata_r, wstrb_r);
        end
        if (wr_capture_compare_value) begin
            capture_compare_value_nxt = merge16(capture_compare_value_r, wdata_r, wstrb_r);
        end
        if (wr_lo && waddr_r == `OFS_CTRL_B) begin
            phase_nxt = FP_IDLE;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= `CNT_BOTTOM;
            capture_compare_value_r <= `CNT_BOTTOM;
            run_r <= 1'b0;
            phase_r <= FP_IDLE;
            match_event <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            capture_compare_value_r <= capture_compare_value_nxt;
            run_r <= run_nxt;
            phase_r <= phase_nxt;
            match_event <= hit;
        end
    end

    // ------------------------------------------------------------
    // Read channel and match flag
    // ------------------------------------------------------------
    logic rd_take;
    logic rd_clr;
    logic wr_clr;
    assign rd_take = arvalid && arready;
    assign rd_clr = rd_take && araddr[7:0] == `OFS_CAPTURE_COMPARE_VALUE && is_capture(mode_r);
    assign wr_clr = wr_lo && waddr_r == `OFS_FLAGS && wdata_r[`FLAG_BIT];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= hit || (flag_r && !(rd_clr || wr_clr));
        end
    end

    function automatic logic [31:0] read_word(input logic [7:0] a);
        unique case (a)
            `OFS_CTRL_A: read_word = {29'h0, clock_source_select_r, en_r};
            `OFS_CTRL_B: read_word = {29'h0, mode_r};
            `OFS_EV_CTRL: read_word = {31'h0, edge_r};
            `OFS_STATUS: read_word = {31'h0, run_r};
            `OFS_FLAGS: read_word = {31'h0, flag_r};
            `OFS_COUNT: read_word = {16'h0000, cnt_r};
            `OFS_CAPTURE_COMPARE_VALUE: read_word = {16'h0000, capture_compare_value_r};
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else begin
            if (rd_take) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= read_word(araddr[7:0]);
                rresp <= is_mapped(araddr[7:0]) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_fp_low;
        en_r && mode_r == M_MATCH_EVENT_FLAG_FRQPW && phase_r == FP_LOW;
    endsequence
    sequence s_fp_stop;
        rise_e && !wr_capture_compare_value;
    endsequence

    reset_mode_a: assert property ($past(rst) |-> mode_r == M_PERIODIC && !en_r)
        else $error("mode not periodic after reset");
    periodic_top_a: assert property (en_r && mode_r == M_PERIODIC && tick
        && cnt_r == capture_compare_value_r && !wr_count |=> cnt_r == `CNT_BOTTOM && match_event && flag_r)
        else $error("periodic match missed");
    periodic_wrap_a: assert property (en_r && mode_r == M_PERIODIC && tick
        && cnt_r == `CNT_MAX && capture_compare_value_r != `CNT_MAX && !wr_count |=> cnt_r == `CNT_BOTTOM)
        else $error("no wrap at MAX");
    timeout_freeze_a: assert property (en_r && mode_r == M_TIMEOUT && !run_r
        && !sel_e && !wr_count |=> $stable(cnt_r) && !run_r)
        else $error("frozen counter moved");
    timeout_match_a: assert property (en_r && mode_r == M_TIMEOUT && run_r && tick
        && !stop_e && cnt_r == capture_compare_value_r |=> match_event)
        else $error("time-out match missed");
    capture_copy_a: assert property (en_r && mode_r == M_MATCH_EVENT_FLAG_EVENT && sel_e
        && !wr_capture_compare_value |=> capture_compare_value_r == $past(cnt_r) && flag_r ##1 !match_event)
        else $error("capture lost");
    read_clear_a: assert property (rd_clr && !hit |=> !flag_r)
        else $error("capture read kept flag");
    freq_restart_a: assert property (en_r && mode_r == M_MATCH_EVENT_FLAG_FREQ && sel_e
        && !wr_count && !wr_capture_compare_value |=> cnt_r == `CNT_BOTTOM && capture_compare_value_r == $past(cnt_r))
        else $error("frequency capture wrong");
    width_capture_a: assert property (en_r && mode_r == M_MATCH_EVENT_FLAG_PW && fall_e
        && !wr_capture_compare_value |=> capture_compare_value_r == $past(cnt_r) && match_event)
        else $error("width capture wrong");
    combined_stop_a: assert property (s_fp_low ##0 s_fp_stop |=> !run_r
        && flag_r && phase_r == FP_DONE)
        else $error("combined stop wrong");
endmodule : event_timer_unit
`default_nettype wire

// *** rtl/event_timer_map.svh ***
// Register offsets, field positions, reset values and timing counts of the timer.
`ifndef EVENT_TIMER_MAP_SVH
`define EVENT_TIMER_MAP_SVH
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_EV_CTRL 8'h08
`define OFS_STATUS 8'h0C
`define OFS_FLAGS 8'h10
`define OFS_COUNT 8'h14
`define OFS_CAPTURE_COMPARE_VALUE 8'h18
`define ENABLE_BIT 0
`define CLOCK_SOURCE_SELECT_LSB 1
`define CLOCK_SOURCE_SELECT_MSB 2
`define MODE_MSB 2
`define EDGE_BIT 0
`define RUN_BIT 0
`define FLAG_BIT 0
`define CLOCK_SOURCE_SELECT_PER 2'h0
`define CLOCK_SOURCE_SELECT_DIV2 2'h1
`define CLOCK_SOURCE_SELECT_COMP 2'h2
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hFFFF
`define CNT_ONE 16'h0001
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/event_timer_pkg.sv ***
// Types shared by the event capture timer.
package event_timer_pkg;
    typedef enum logic [2:0] {
        M_PERIODIC, M_TIMEOUT, M_MATCH_EVENT_FLAG_EVENT, M_MATCH_EVENT_FLAG_FREQ,
        M_MATCH_EVENT_FLAG_PW, M_MATCH_EVENT_FLAG_FRQPW, M_SINGLE, M_PWM8
    } mode_t;
    typedef enum logic [1:0] {FP_IDLE, FP_HIGH, FP_LOW, FP_DONE} fp_phase_t;
endpackage : event_timer_pkg

// *** verif/event_link_model.sv ***
// Behavioural model of the event router and the companion timer feeding the timer.
`timescale 1ns/1ps
`default_nettype none
module event_link_model (
    input wire logic mclk,
    output logic event_in,
    output logic companion_tick
);
    // ----------------------------------------
    // Drive levels and ticks
    // ----------------------------------------
    initial begin
        event_in = 1'b0;
        companion_tick = 1'b0;
    end

    task automatic level(input logic v);
        event_in <= v;
        repeat (3) @(posedge mclk);
    endtask : level

    // one companion tick per two clocks
    task automatic ticks(input int n);
        repeat (n) begin
            companion_tick <= 1'b1;
            @(posedge mclk);
            companion_tick <= 1'b0;
            @(posedge mclk);
        end
    endtask : ticks
endmodule : event_link_model
`default_nettype wire

// *** verif/test_event_timer_unit.sv ***
// Self-checking testbench of the event capture timer.
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_map.svh"
`define CHECK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module test_event_timer_unit;
    logic mclk, rst, event_in, companion_tick, match_event;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int fail_count = 0;
    int check_count = 0;
    int ev_count = 0;
    int ev0, i;

    event_timer_unit dut (.mclk(mclk), .rst(rst), .event_in(event_in),
        .companion_tick(companion_tick), .match_event(match_event), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    event_link_model link (.mclk(mclk), .event_in(event_in), .companion_tick(companion_tick));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (match_event === 1'b1) ev_count <= ev_count + 1;
    end

    // ----------------------------------------
    // Register bus tasks
    // ----------------------------------------
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] v,
                       output logic [31:0] q, output logic [1:0] resp);
        int n;
        q = 32'h0;
        resp = 2'h3;
        if (wr) begin
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
            if (wr && bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
            if (!wr && rvalid === 1'b1) begin
                q = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        @(posedge mclk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v, d, r);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0, d, r);
        `CHECK(nm, e, d)
    endtask : rchk

    task automatic setup(input logic [2:0] m, input logic e, input logic [15:0] top,
                         input logic [15:0] cnt, input logic [31:0] ctl);
        wr(`OFS_CTRL_A, 32'h0);
        wr(`OFS_CTRL_B, {29'h0, m});
        wr(`OFS_EV_CTRL, {31'h0, e});
        wr(`OFS_CAPTURE_COMPARE_VALUE, {16'h0, top});
        wr(`OFS_COUNT, {16'h0, cnt});
        wr(`OFS_FLAGS, 32'h1);
        wr(`OFS_CTRL_A, ctl);
        ev0 = ev_count;
    endtask : setup

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    initial begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        results();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rchk(`OFS_CTRL_A, 32'h0, "ctrl_a");
        rchk(`OFS_CTRL_B, 32'h0, "mode_rst");
        rchk(`OFS_STATUS, 32'h0, "run_rst");
        rchk(`OFS_COUNT, 32'h0, "count_rst");
        bus(1'b1, 8'h1C, 32'h5A, d, r);
        `CHECK("wr_unmapped", `RESP_SLVERR, r)
        bus(1'b0, 8'h1C, 32'h0, d, r);
        `CHECK("rd_unmapped", `RESP_SLVERR, r)
        wr(`OFS_CAPTURE_COMPARE_VALUE, 32'h1234);
        wstrb <= 4'h1;
        wr(`OFS_CAPTURE_COMPARE_VALUE, 32'hFFFF_FF56);
        rchk(`OFS_CAPTURE_COMPARE_VALUE, 32'h1256, "strb_lo");
        wstrb <= 4'h2;
        wr(`OFS_CAPTURE_COMPARE_VALUE, 32'h0000_7800);
        rchk(`OFS_CAPTURE_COMPARE_VALUE, 32'h7856, "strb_hi");
        wr(`OFS_CTRL_A, 32'h1);
        rchk(`OFS_CTRL_A, 32'h0, "strb_ctl");
        wstrb <= 4'h0;
        wr(`OFS_COUNT, 32'h0000_FFFF);
        rchk(`OFS_COUNT, 32'h0, "strb_none");
        wstrb <= 4'hF;
        for (i = 0; i < 8; i++) begin
            wr(`OFS_CTRL_B, i);
            rchk(`OFS_CTRL_B, i, "mode_rb");
        end
        setup(3'd0, 1'b0, 16'h0005, 16'h0000, 32'h5);
        rchk(`OFS_STATUS, 32'h1, "run_on");
        link.ticks(5);
        rchk(`OFS_COUNT, 32'h5, "at_top");
        rchk(`OFS_FLAGS, 32'h0, "no_flag");
        link.ticks(1);
        rchk(`OFS_COUNT, 32'h0, "restart");
        rchk(`OFS_FLAGS, 32'h1, "per_flag");
        `CHECK("per_ev", ev0 + 1, ev_count)
        setup(3'd0, 1'b0, 16'h0003, 16'hFFFE, 32'h5);
        link.ticks(2);
        rchk(`OFS_COUNT, 32'h0, "wrap");
        rchk(`OFS_FLAGS, 32'h0, "wrap_flag");
        link.ticks(4);
        rchk(`OFS_COUNT, 32'h0, "wrap_top");
        `CHECK("wrap_ev", ev0 + 1, ev_count)
        setup(3'd0, 1'b0, 16'hFFFF, 16'h0000, 32'h3);
        repeat (40) @(posedge mclk);
        wr(`OFS_CTRL_A, 32'h0);
        bus(1'b0, `OFS_COUNT, 32'h0, d, r);
        `CHECK("div2", 1'b1, d >= 32'd18 && d <= 32'd26)
        setup(3'd1, 1'b0, 16'h0002, 16'h0000, 32'h5);
        link.ticks(2);
        rchk(`OFS_COUNT, 32'h0, "to_wait");
        link.level(1'b1);
        rchk(`OFS_STATUS, 32'h1, "to_run");
        link.ticks(4);
        link.level(1'b0);
        link.ticks(2);
        rchk(`OFS_COUNT, 32'h4, "to_frozen");
        rchk(`OFS_STATUS, 32'h0, "to_stop");
        wr(`OFS_STATUS, 32'h1);
        rchk(`OFS_CAPTURE_COMPARE_VALUE, 32'h2, "to_top");
        link.ticks(1);
        rchk(`OFS_COUNT, 32'h4, "to_still");
        rchk(`OFS_FLAGS, 32'h1, "to_flag");
        `CHECK("to_ev", ev0 + 1, ev_count)
        link.level(1'b1);
        rchk(`OFS_STATUS, 32'h1, "to_again");
        link.level(1'b0);
        for (i = 0; i < 2; i++) begin
            setup(3'd2, i[0], 16'h0000, 16'h1230, 32'h5);
            link.level(1'b1);
            link.ticks(3);
            link.level(1'b0);
            rchk(`OFS_FLAGS, 32'h1, "cap_flag");
            rchk(`OFS_CAPTURE_COMPARE_VALUE, 32'h1230 + 3 * i, "cap_val");
            rchk(`OFS_FLAGS, 32'h0, "cap_clr");
            `CHECK("cap_ev", ev0 + 1, ev_count)
        end
        for (i = 0; i < 2; i++) begin
            setup(3'd3, i[0], 16'h0000, 16'h0000, 32'h5);
            link.level(1'b1);
            if (i == 1) link.level(1'b0);
            link.ticks(7);
            link.level(i[0]);
            link.ticks(2);
            link.level(~i[0]);
            rchk(`OFS_CAPTURE_COMPARE_VALUE, 32'h9, "freq");
            link.level(1'b0);
        end
        setup(3'd4, 1'b0, 16'h0000, 16'h0000, 32'h5);
        for (i = 6; i > 3; i -= 2) begin
            link.level(1'b1);
            link.ticks(i);
            link.level(1'b0);
            link.ticks(2);
            rchk(`OFS_CAPTURE_COMPARE_VALUE, i, "pw_val");
        end
        `CHECK("pw_ev", ev0 + 2, ev_count)
        setup(3'd5, 1'b0, 16'h0000, 16'h0000, 32'h5);
        link.level(1'b1);
        link.ticks(3);
        link.level(1'b0);
        link.ticks(2);
        link.level(1'b1);
        link.ticks(2);
        rchk(`OFS_STATUS, 32'h0, "fw_stop");
        rchk(`OFS_COUNT, 32'h5, "fw_count");
        rchk(`OFS_FLAGS, 32'h1, "fw_flag");
        rchk(`OFS_CAPTURE_COMPARE_VALUE, 32'h3, "fw_width");
        rchk(`OFS_FLAGS, 32'h0, "fw_clr");
        `CHECK("fw_ev", ev0 + 1, ev_count)
        link.level(1'b0);
        link.level(1'b1);
        link.ticks(1);
        rchk(`OFS_COUNT, 32'h1, "fw_again");
        results();
    end
endmodule : test_event_timer_unit
`default_nettype wire
